/* vcg_top.sv */
// Video capture glue: field arming, blanking gate, word packing strobes, fill tracking
// Operation
// R01: After reset release the decoder pulses vertical reference at next field start.
// R02: Decoder holds active video valid low during blanking samples.
// R03: Decoder raises active video valid for the whole active part of a line.
// R04: Decoder drops active video valid at line end until next visible line.
// R05: Gated valid words strobe low-half and high-half FIFO pairs alternately.
// R06: Toggle true output drives low strobe, inverted output drives high strobe; here the low strobe uses !toggle_r and the high strobe toggle_r.
// R07: Half-full is presented to the host as an interrupt event.
// R08: Host repeats wait for half-full then drain until software disables capture.
// R09: Host drains 8k words in about 400 us, before FIFOs refill.
// R10: Bus-matching option writes every word to one FIFO, which packs pairs.
// R11: Write enable is active video valid AND the field-start flip-flop.
// R12: Half-full asserts at 8k of 16k entries; host drains at most 8k.
// R13: Host flag resets both flip-flops and all FIFOs; restart at next field.
// R14: Toggle starts known after reset, first word goes to low half.
`timescale 1ns/1ps
module vcg_top (
   // Clock and reset
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_rst_n,
   // Decoder side, asynchronous to i_ref_clk
   input  wire logic                         i_pix_clk,
   input  wire logic [vcg_pkg::DATA_W-1:0]   i_pix_data,
   input  wire logic                         i_active_video_valid,
   input  wire logic                         i_vref,
   input  wire logic                         i_field,
   // Host side
   input  wire logic                         i_capture_reset,
   input  wire logic                         i_bank_one_select_n,
   input  wire logic                         i_bus_match,
   // External FIFO side
   input  wire logic                         i_fifo_ready,
   output logic                              o_low_half_write_strobe,
   output logic                              o_high_half_write_strobe,
   output logic [vcg_pkg::DATA_W-1:0]        o_fifo_data,
   output logic                              o_fifo_reset,
   output logic                              o_fifo_half_full_flag,
   output logic                              o_half_full_event,
   output logic                              o_overrun
);
   // Two-flop synchronisers for every decoder pin and the host capture-reset and select pins; i_bus_match is used directly
   localparam int unsigned SW = vcg_pkg::DATA_W + 6;
   // Select pin idles high; a zero here would fake a read edge after reset
   localparam logic [SW-1:0] SYNC_RST = 22'h01_0000;
   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;
   logic          pclk_d_r;
   logic          vref_d_r;
   logic          sel_d_r;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_r <= SYNC_RST;
         sync2_r <= SYNC_RST;
      end else begin
         sync1_r <= {i_pix_clk, i_active_video_valid, i_vref, i_field,
                     i_capture_reset, i_bank_one_select_n, i_pix_data};
         sync2_r <= sync1_r;
      end
   end

   logic                       pclk_s;
   logic                       avv_s;
   logic                       vref_s;
   logic                       field_s;
   logic                       crst_s;
   logic                       sel_n_s;
   logic [vcg_pkg::DATA_W-1:0] data_s;
   assign {pclk_s, avv_s, vref_s, field_s, crst_s, sel_n_s, data_s} = sync2_r;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pclk_d_r <= 1'b0;
         vref_d_r <= 1'b0;
         sel_d_r  <= 1'b1;
      end else begin
         pclk_d_r <= pclk_s;
         vref_d_r <= vref_s;
         sel_d_r  <= sel_n_s;
      end
   end

   // Data launches on the rising pixel edge, so sample at the falling one
   logic pix_fall;
   logic vref_rise;
   logic read_word;
   logic clr;
   assign pix_fall  = pclk_d_r && !pclk_s;
   assign vref_rise = vref_s && !vref_d_r;
   assign read_word = sel_d_r && !sel_n_s;
   assign clr       = crst_s;

   // Field-start flip-flop: arms on vertical reference of field zero
   logic armed_r;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         armed_r <= 1'b0;
      end else if (clr) begin
         armed_r <= 1'b0; // R13
      end else if (vref_rise && !field_s) begin
         armed_r <= 1'b1;
      end
   end

   // Blanking never reaches the buffer
   logic                       wr_en;
   logic                       push;
   logic                       in_ready;
   logic                       out_valid;
   logic                       pop;
   logic [vcg_pkg::DATA_W-1:0] out_data;
   assign wr_en = avv_s && armed_r; // R11
   assign push  = wr_en && pix_fall;

   vcg_buf u_buf (
      .i_clk       (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_sclr      (clr),
      .i_in_valid  (push),
      .o_in_ready  (in_ready),
      .i_in_data   (data_s),
      .o_out_valid (out_valid),
      .i_out_ready (pop),
      .o_out_data  (out_data)
   );

   // Decoder cannot be stalled; a word lost to a full buffer is flagged
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_overrun <= 1'b0;
      end else if (push && !in_ready) begin
         o_overrun <= 1'b1;
      end else if (clr) begin
         o_overrun <= 1'b0;
      end
   end

   // Toggle and strobes; one idle cycle between strobes keeps them distinct
   logic toggle_r;
   logic strobe_busy;
   assign strobe_busy = o_low_half_write_strobe || o_high_half_write_strobe;
   assign pop         = out_valid && i_fifo_ready && !strobe_busy && !clr;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         toggle_r <= vcg_pkg::TOGGLE_RST; // R14
      end else if (clr) begin
         toggle_r <= vcg_pkg::TOGGLE_RST; // R14
      end else if (pop) begin
         toggle_r <= ~toggle_r; // R06
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_low_half_write_strobe  <= 1'b0;
         o_high_half_write_strobe <= 1'b0;
         o_fifo_data              <= '0;
      end else begin
         o_low_half_write_strobe  <= pop && (!toggle_r || i_bus_match); // R05 R06 R10
         o_high_half_write_strobe <= pop && toggle_r && !i_bus_match; // R05 R06 R10
         if (pop) begin
            o_fifo_data <= out_data;
         end
      end
   end

   // Fill level of the external FIFOs in 32-bit words
   logic [vcg_pkg::CNT_W-1:0] cnt_r;
   logic [vcg_pkg::CNT_W-1:0] cnt_nxt;
   logic                      word_done;
   assign word_done = pop && toggle_r;

   always_comb begin
      cnt_nxt = cnt_r;
      if (word_done && !read_word && cnt_r != vcg_pkg::FIFO_DEPTH) begin
         cnt_nxt = cnt_r + 15'h0001;
      end else if (read_word && !word_done && cnt_r != vcg_pkg::CNT_RST) begin
         cnt_nxt = cnt_r - 15'h0001;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r                 <= vcg_pkg::CNT_RST;
         o_fifo_half_full_flag <= 1'b0;
         o_half_full_event     <= 1'b0;
         o_fifo_reset          <= 1'b0;
      end else begin
         cnt_r                 <= clr ? vcg_pkg::CNT_RST : cnt_nxt; // R13
         o_fifo_half_full_flag <= !clr && (cnt_nxt >= vcg_pkg::HALF_LEVEL); // R12
         o_half_full_event     <= !clr && !o_fifo_half_full_flag
                                  && (cnt_nxt >= vcg_pkg::HALF_LEVEL); // R07
         o_fifo_reset          <= clr; // R13
      end
   end

   // Checks
   sequence s_pop_low;
      pop && !toggle_r && !i_bus_match;
   endsequence
   sequence s_low_only;
      o_low_half_write_strobe && !o_high_half_write_strobe;
   endsequence

   a_low_first_word: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R05
      s_pop_low |=> s_low_only) else $error("low strobe missing");
   a_toggle_pair: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R06
      pop && toggle_r && !i_bus_match |=> o_high_half_write_strobe ##1 !strobe_busy)
      else $error("high strobe wrong");
   a_half_event: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R07
      $rose(o_fifo_half_full_flag) |-> o_half_full_event) else $error("no half event");
   a_match_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R10
      i_bus_match && pop |=> !o_high_half_write_strobe && o_low_half_write_strobe)
      else $error("bus match strobe wrong");
   a_gate_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R11
      push |-> armed_r && avv_s) else $error("ungated write");
   a_half_level: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R12
      !$past(clr) |-> o_fifo_half_full_flag == (cnt_r >= vcg_pkg::HALF_LEVEL))
      else $error("half flag level wrong");
   a_drain_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R12
      read_word && !word_done && !clr && cnt_r != vcg_pkg::CNT_RST
      |=> cnt_r == $past(cnt_r) - 15'h0001) else $error("drain count wrong");
   a_reset_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R13
      clr |=> !armed_r && cnt_r == vcg_pkg::CNT_RST && o_fifo_reset)
      else $error("capture reset incomplete");
   a_first_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R14
      clr ##1 !clr |-> !toggle_r && !o_high_half_write_strobe)
      else $error("toggle not cleared");
endmodule

/* vcg_pkg.sv */
// Shared constants for the video capture FIFO glue
package vcg_pkg;
   localparam int unsigned DATA_W      = 16;
   localparam int unsigned CNT_W       = 15;
   localparam logic [14:0] FIFO_DEPTH  = 15'h4000;
   localparam logic [14:0] HALF_LEVEL  = 15'h2000;
   localparam logic [14:0] CNT_RST     = 15'h0000;
   localparam logic        TOGGLE_RST  = 1'b0;
   localparam int unsigned BUF_DEPTH   = 2;
endpackage

/* vcg_buf.sv */
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module vcg_buf (
   // Clock and reset
   input  wire logic                         i_clk,
   input  wire logic                         i_rst_n,
   input  wire logic                         i_sclr,
   // Fill side
   input  wire logic                         i_in_valid,
   output logic                              o_in_ready,
   input  wire logic [vcg_pkg::DATA_W-1:0]   i_in_data,
   // Drain side
   output logic                              o_out_valid,
   input  wire logic                         i_out_ready,
   output logic [vcg_pkg::DATA_W-1:0]        o_out_data
);
   logic [vcg_pkg::DATA_W-1:0] mem_r [vcg_pkg::BUF_DEPTH];
   logic                       wr_ptr_r;
   logic                       rd_ptr_r;
   logic [1:0]                 cnt_r;
   logic                       push;
   logic                       pop;

   assign o_in_ready  = (cnt_r != 2'h2);
   assign o_out_valid = (cnt_r != 2'h0);
   assign o_out_data  = mem_r[rd_ptr_r];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         cnt_r    <= 2'h0;
      end else if (i_sclr) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         cnt_r    <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

/* vcg_dec_model.sv */
// Decoder model: free-running pixel clock, field reference, line words
`timescale 1ns/1ps
module vcg_dec_model (
   // Decoder pins
   output logic        o_pix_clk,
   output logic [15:0] o_pix_data,
   output logic        o_active_video_valid,
   output logic        o_vref,
   output logic        o_field
);
   initial begin
      o_pix_clk = 1'b0;
      o_pix_data = 16'h5a5a;
      o_active_video_valid = 1'b0;
      o_vref = 1'b0;
      o_field = 1'b1;
   end
   // Line-locked clock runs free, so it keeps toggling between lines
   always #400 o_pix_clk = ~o_pix_clk;
   // Reference pulse lasts one pixel period at the start of a field
   task automatic field_start(input logic fld);
      @(posedge o_pix_clk);
      o_field <= fld;
      o_vref <= 1'b1;
      @(posedge o_pix_clk);
      o_vref <= 1'b0;
   endtask
   // Words base+i; valid only over the active part, low over blanking
   task automatic send_line(input int n, input logic vld, input logic [15:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge o_pix_clk);
         o_active_video_valid <= vld;
         o_pix_data <= base + 16'(i);
      end
      @(posedge o_pix_clk);
      o_active_video_valid <= 1'b0;
      o_pix_data <= ~o_pix_data;
   endtask
endmodule

/* testbench.sv */
// Self-checking bench for the capture glue driven by the decoder model
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
   logic                          clk, rst_n, pclk, avv, vref, fld;
   logic                          cap_rst, bmatch, rdy, lo, hi, frst, hf, ovr, sel_n, hfe;
   logic [vcg_pkg::DATA_W-1:0]    pdata, fdata;
   logic [16:0]                   q[$];
   int                            n_mismatch, compares, cyc;
   vcg_dec_model u_dec (.o_pix_clk(pclk), .o_pix_data(pdata),
      .o_active_video_valid(avv), .o_vref(vref), .o_field(fld));
   vcg_top u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_pix_clk(pclk),
      .i_pix_data(pdata), .i_active_video_valid(avv), .i_vref(vref), .i_field(fld),
      .i_capture_reset(cap_rst), .i_bank_one_select_n(sel_n), .i_bus_match(bmatch),
      .i_fifo_ready(rdy), .o_low_half_write_strobe(lo), .o_high_half_write_strobe(hi),
      .o_fifo_data(fdata), .o_fifo_reset(frst), .o_fifo_half_full_flag(hf),
      .o_half_full_event(hfe), .o_overrun(ovr));
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      cap_rst = 1'b0;
      bmatch = 1'b0;
      rdy = 1'b1;
      sel_n = 1'b1;
   end
   always #50 clk = ~clk;
   // Collect every strobe; both halves at once would tear the 32-bit word
   always @(posedge clk) begin
      `CHK(lo & hi, 1'b0)
      if (lo || hi) q.push_back({hi, fdata});
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Wait for n strobes under a bound, then judge order, halves and data
   task automatic expect_words(input int n, input logic [15:0] base, input logic bm);
      int k;
      k = 0;
      while (q.size() < n && k < 300) begin
         @(negedge clk);
         k++;
      end
      repeat (20) @(negedge clk);
      `CHK(q.size(), n)
      for (int i = 0; i < n && i < q.size(); i++) begin
         `CHK(q[i][16], bm ? 1'b0 : 1'(i % 2))
         `CHK(q[i][15:0], base + 16'(i))
      end
      q.delete();
   endtask
   task automatic s_arming;
      u_dec.field_start(1'b1);
      u_dec.send_line(4, 1'b1, 16'h1000);
      expect_words(0, 16'h0000, 1'b0);
      u_dec.field_start(1'b0);
      u_dec.send_line(6, 1'b1, 16'h2000);
      expect_words(6, 16'h2000, 1'b0);
      u_dec.send_line(5, 1'b0, 16'h3000);
      expect_words(0, 16'h0000, 1'b0);
   endtask
   task automatic s_bus_match;
      @(posedge clk);
      bmatch <= 1'b1;
      u_dec.send_line(4, 1'b1, 16'h4000);
      expect_words(4, 16'h4000, 1'b1);
      @(posedge clk);
      bmatch <= 1'b0;
   endtask
   // Short stall is absorbed by the two-entry buffer; a long one drops words
   task automatic s_stall;
      @(posedge clk);
      rdy <= 1'b0;
      u_dec.send_line(2, 1'b1, 16'h5000);
      @(posedge clk);
      rdy <= 1'b1;
      expect_words(2, 16'h5000, 1'b0);
      `CHK(ovr, 1'b0)
      @(posedge clk);
      rdy <= 1'b0;
      u_dec.send_line(4, 1'b1, 16'h6000);
      @(negedge clk);
      `CHK(ovr, 1'b1)
      @(posedge clk);
      rdy <= 1'b1;
      expect_words(2, 16'h6000, 1'b0);
   endtask
   // Host drains faster than the decoder fills; a read at empty is ignored
   task automatic s_host_drain;
      u_dec.send_line(4, 1'b1, 16'h9000);
      expect_words(4, 16'h9000, 1'b0);
      `CHK(u_dut.cnt_r, 15'h0004)
      repeat (5) begin
         @(posedge clk);
         sel_n <= 1'b0;
         repeat (2) @(posedge clk);
         sel_n <= 1'b1;
         repeat (2) @(posedge clk);
      end
      repeat (6) @(negedge clk);
      `CHK(u_dut.cnt_r, 15'h0000)
      `CHK({hf, hfe}, 2'b00)
   endtask
   // Host clear resets FIFOs and flip-flops; capture waits for a new field
   task automatic s_capture_reset;
      @(posedge clk);
      cap_rst <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK(frst, 1'b1)
      @(posedge clk);
      cap_rst <= 1'b0;
      repeat (6) @(negedge clk);
      `CHK(ovr, 1'b0)
      `CHK(hf, 1'b0)
      u_dec.send_line(3, 1'b1, 16'h7000);
      expect_words(0, 16'h0000, 1'b0);
      u_dec.field_start(1'b0);
      u_dec.send_line(4, 1'b1, 16'h8000);
      expect_words(4, 16'h8000, 1'b0);
   endtask
   initial begin
      n_mismatch = 0;
      compares = 0;
      cyc = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      s_arming();
      s_bus_match();
      s_stall();
      s_capture_reset();
      s_host_drain();
      give_verdict();
   end
endmodule
